// >>> src/ocf_cfg.svh
// Purpose: Constants for the over-current fault response block
// Assumes: 20 MHz clock, register port at the printed command codes
// Notes:   All offsets, fields, resets and counts live here
// What this block does
// - Hold 16-bit linear threshold, use as limit
// - Every mode sets status bit, notifies host
// - Mode 00: run forever, brickwall current limit
// - Mode 01: limit while voltage above cutoff
// - Mode 01: below cutoff, shut down, retry
// - Mode 10: limit for programmed delay time
// - Mode 10: still limiting at expiry, retry
// - Mode 11: shut down immediately, then retry
// - Retry count from action bits five..three
// - Retry zero: stay off until cleared
// - Codes one..six: that many tries, then off
// - Retry all ones: retry without limit
// - Restart spacing is two^code time units
// - Delay code n means two^n units
// - Unit length from separate time-unit register
// - Endless retry stops on off, bias, fault
`ifndef OCF_CFG_SVH
`define OCF_CFG_SVH
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define OCF_ADDR_THRESHOLD  8'h46
`define OCF_ADDR_ACTION     8'h47
`define OCF_ADDR_TIME_UNIT  8'hc8
`define OCF_RST_THRESHOLD   16'h0000
`define OCF_RST_ACTION      8'hc0
`define OCF_RST_TIME_UNIT   16'h0001
// ----------------------------------------------------------------
// Action fields
// ----------------------------------------------------------------
`define OCF_MODE_HI         7
`define OCF_MODE_LO         6
`define OCF_RETRY_HI        5
`define OCF_RETRY_LO        3
`define OCF_DELAY_HI        2
`define OCF_DELAY_LO        0
`define OCF_RETRY_NONE      3'h0
`define OCF_RETRY_ENDLESS   3'h7
// ----------------------------------------------------------------
// Timing: one time-unit tick is 1 us
// ----------------------------------------------------------------
`define OCF_TICK_NS         1000
`define OCF_CLK_NS          50
`define OCF_TICK_CYCLES     (`OCF_TICK_NS / `OCF_CLK_NS)
`endif

// >>> src/ocf_pkg.sv
// Purpose: Types for the over-current fault response block
// Assumes: Constants come from ocf_cfg.svh
// Notes:   Types only
package ocf_pkg;
    typedef enum logic [1:0] {
        ModeIgnore,
        ModeConditioned,
        ModeDelayRetry,
        ModeShutRetry
    } ocf_mode_e;
    typedef enum logic [2:0] {
        StOff,
        StRun,
        StLimit,
        StWait,
        StLatched
    } ocf_state_e;
endpackage

// >>> src/ocf_timer_if.sv
// Purpose: Link between fault sequencer and delay timer
// Assumes: One clock domain
// Notes:   Start loads, done pulses once on expiry
`timescale 1ns/1ps
`default_nettype none
interface ocf_timer_if;
    logic       start;
    logic       clear;
    logic [2:0] code;
    logic       done;
    modport ctrl  (output start, output clear, output code, input done);
    modport timer (input start, input clear, input code, output done);
endinterface
`default_nettype wire

// >>> src/ocf_delay_timer.sv
// Purpose: Counts 2^code time units of programmable length
// Assumes: unitLen of zero is treated as one tick
// Notes:   Restart on start; clear aborts
`timescale 1ns/1ps
`default_nettype none
`include "ocf_cfg.svh"
module ocf_delay_timer #(
    parameter int TICK_CYCLES = `OCF_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // Unit length in ticks
    input  wire logic [15:0] unitLen,
    // Control link
    ocf_timer_if.timer       tmr
);
    logic [15:0] tickCnt;
    logic [15:0] unitCnt;
    logic [7:0]  unitsLeft;
    logic        running;
    logic        doneQ;
    wire         tickEnd = (tickCnt == 16'(TICK_CYCLES - 1));
    wire         unitEnd = tickEnd && (unitCnt + 16'h0001 >= unitLen);
    wire         lastUnit = unitEnd && (unitsLeft == 8'h01);
    wire [7:0]   unitsInit = 8'h01 << tmr.code;

    assign tmr.done = doneQ;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tickCnt   <= 16'h0000;
            unitCnt   <= 16'h0000;
            unitsLeft <= 8'h00;
            running   <= 1'b0;
            doneQ     <= 1'b0;
        end else if (tmr.clear) begin
            running <= 1'b0;
            doneQ   <= 1'b0;
        end else if (tmr.start) begin
            tickCnt   <= 16'h0000;
            unitCnt   <= 16'h0000;
            unitsLeft <= unitsInit;
            running   <= 1'b1;
            doneQ     <= 1'b0;
        end else if (running) begin
            tickCnt <= tickEnd ? 16'h0000 : tickCnt + 16'h0001;
            unitCnt <= unitEnd ? 16'h0000 : (tickEnd ? unitCnt + 16'h0001 : unitCnt);
            if (unitEnd) begin
                unitsLeft <= unitsLeft - 8'h01;
            end
            running <= !lastUnit;
            doneQ   <= lastUnit;
        end else begin
            doneQ <= 1'b0;
        end
    end

    chk_done_single: assert property (@(posedge clock) disable iff (sys_rst)
        tmr.done |=> !tmr.done) else $error("timer done longer than one cycle");
endmodule
`default_nettype wire

// >>> src/ocf_fault_response.sv
// Purpose: Over-current fault response sequencer with register port
// Assumes: Register port is a simple command/data write/read strobe
// Notes:   Fault and voltage inputs are synchronised pins
`timescale 1ns/1ps
`default_nettype none
`include "ocf_cfg.svh"
module ocf_fault_response #(
    parameter int TICK_CYCLES = `OCF_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrite,
    input  wire logic [15:0] regWdata,
    output logic [15:0]      regRdata,
    // Analog comparator and supervisory pins
    input  wire logic        overCurrent,
    input  wire logic        belowCutoff,
    input  wire logic        enableCmd,
    input  wire logic        biasGood,
    input  wire logic        otherFault,
    input  wire logic        faultClear,
    // Power stage control and status
    output logic [15:0]      currentLimit,
    output logic             limitActive,
    output logic             outputEnable,
    output logic             faultStatus,
    output logic             hostAlert
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [15:0] currentFaultThreshold;
    logic [7:0]  currentFaultAction;
    logic [15:0] timeUnit;
    wire wrThr  = regWrite && (regAddr == `OCF_ADDR_THRESHOLD);
    wire wrAct  = regWrite && (regAddr == `OCF_ADDR_ACTION);
    wire wrUnit = regWrite && (regAddr == `OCF_ADDR_TIME_UNIT);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            currentFaultThreshold <= `OCF_RST_THRESHOLD;
            currentFaultAction    <= `OCF_RST_ACTION;
            timeUnit              <= `OCF_RST_TIME_UNIT;
        end else begin
            if (wrThr)
                currentFaultThreshold <= regWdata;
            if (wrAct)
                currentFaultAction <= regWdata[7:0];
            if (wrUnit)
                timeUnit <= regWdata;
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers: change counts when stages two and three agree
    // ----------------------------------------------------------------
    logic [5:0] s1, s2, s3, clean;
    wire  [5:0] pinsIn = {overCurrent, belowCutoff, enableCmd, biasGood, otherFault, faultClear};
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s1    <= 6'h00;
            s2    <= 6'h00;
            s3    <= 6'h00;
            clean <= 6'h00;
        end else begin
            s1 <= pinsIn;
            s2 <= s1;
            s3 <= s2;
            clean <= (s2 & s3) | (clean & (s2 | s3));
        end
    end
    wire ocIn    = clean[5];
    wire lowV    = clean[4];
    wire enIn    = clean[3];
    wire biasIn  = clean[2];
    wire othIn   = clean[1];
    wire clrIn   = clean[0];
    wire runOk   = enIn && biasIn && !othIn;

    // ----------------------------------------------------------------
    // Action decode
    // ----------------------------------------------------------------
    wire ocf_pkg::ocf_mode_e mode = ocf_pkg::ocf_mode_e'(currentFaultAction[`OCF_MODE_HI:`OCF_MODE_LO]);
    wire [2:0] retryCode = currentFaultAction[`OCF_RETRY_HI:`OCF_RETRY_LO];
    wire [2:0] delayCode = currentFaultAction[`OCF_DELAY_HI:`OCF_DELAY_LO];

    ocf_timer_if tmr ();
    ocf_delay_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
        .clock   (clock),
        .sys_rst (sys_rst),
        .unitLen (timeUnit),
        .tmr     (tmr)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    ocf_pkg::ocf_state_e state, next_state;
    logic [2:0] triesUsed;
    logic       ocPrev;
    wire ocRise   = ocIn && !ocPrev;
    wire retryOk  = (retryCode == `OCF_RETRY_ENDLESS) || (triesUsed < retryCode);
    wire tripNow  = (state == ocf_pkg::StRun) && ocIn && (mode == ocf_pkg::ModeShutRetry);
    wire tripLowV = (state == ocf_pkg::StLimit) && (mode == ocf_pkg::ModeConditioned) && lowV;
    wire tripDly  = (state == ocf_pkg::StLimit) && (mode == ocf_pkg::ModeDelayRetry)
                    && tmr.done && ocIn;
    wire trip     = tripNow || tripLowV || tripDly;
    wire enterLim = (state == ocf_pkg::StRun) && ocIn && (mode != ocf_pkg::ModeShutRetry);
    wire reset_seq = clrIn || !runOk;

    always_comb begin
        next_state = state;
        unique case (state)
            ocf_pkg::StOff:
                if (runOk && !clrIn)
                    next_state = ocf_pkg::StRun;
            ocf_pkg::StRun:
                if (tripNow)
                    next_state = retryOk ? ocf_pkg::StWait : ocf_pkg::StLatched;
                else if (enterLim)
                    next_state = ocf_pkg::StLimit;
            ocf_pkg::StLimit:
                if (trip)
                    next_state = retryOk ? ocf_pkg::StWait : ocf_pkg::StLatched;
                else if (!ocIn)
                    next_state = ocf_pkg::StRun;
            ocf_pkg::StWait:
                if (tmr.done)
                    next_state = ocf_pkg::StRun;
            ocf_pkg::StLatched:
                next_state = ocf_pkg::StLatched;
        endcase
        if (reset_seq)
            next_state = ocf_pkg::StOff;
    end

    assign tmr.clear = reset_seq;
    assign tmr.start = (trip && retryOk) || (enterLim && mode == ocf_pkg::ModeDelayRetry);
    assign tmr.code  = delayCode;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state       <= ocf_pkg::StOff;
            triesUsed   <= 3'h0;
            ocPrev      <= 1'b0;
            faultStatus <= 1'b0;
        end else begin
            state  <= next_state;
            ocPrev <= ocIn;
            if (reset_seq)
                triesUsed <= 3'h0;
            else if (trip && retryOk && retryCode != `OCF_RETRY_ENDLESS)
                triesUsed <= triesUsed + 3'h1;
            if (ocRise)
                faultStatus <= 1'b1;
            else if (clrIn)
                faultStatus <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            currentLimit <= `OCF_RST_THRESHOLD;
            outputEnable <= 1'b0;
            limitActive  <= 1'b0;
            regRdata     <= 16'h0000;
        end else begin
            currentLimit <= currentFaultThreshold;
            outputEnable <= (next_state == ocf_pkg::StRun) || (next_state == ocf_pkg::StLimit);
            limitActive  <= (next_state == ocf_pkg::StLimit);
            regRdata     <= (regAddr == `OCF_ADDR_THRESHOLD) ? currentFaultThreshold :
                            (regAddr == `OCF_ADDR_ACTION)    ? {8'h00, currentFaultAction} :
                            (regAddr == `OCF_ADDR_TIME_UNIT) ? timeUnit : 16'h0000;
        end
    end
    assign hostAlert = faultStatus;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_shut_now: assert property (@(posedge clock) disable iff (sys_rst)
        tripNow |=> ##1 !outputEnable) else $error("mode 11 did not shut down");
    chk_ignore_runs: assert property (@(posedge clock) disable iff (sys_rst)
        (state == ocf_pkg::StLimit && mode == ocf_pkg::ModeIgnore && !reset_seq) |=> state != ocf_pkg::StWait)
        else $error("mode 00 shut down");
    chk_lowv_trip: assert property (@(posedge clock) disable iff (sys_rst)
        (tripLowV && !reset_seq) |=> state inside {ocf_pkg::StWait, ocf_pkg::StLatched})
        else $error("mode 01 low voltage did not trip");
    chk_no_retry: assert property (@(posedge clock) disable iff (sys_rst)
        (trip && retryCode == `OCF_RETRY_NONE && !reset_seq) |=> state == ocf_pkg::StLatched)
        else $error("retry zero restarted");
    chk_status_set: assert property (@(posedge clock) disable iff (sys_rst)
        ocRise |=> faultStatus && hostAlert) else $error("status not set");
    chk_clear_seq: assert property (@(posedge clock) disable iff (sys_rst)
        clrIn |=> state == ocf_pkg::StOff && triesUsed == 3'h0) else $error("clear did not reset");
    chk_limit_val: assert property (@(posedge clock) disable iff (sys_rst)
        ##1 currentLimit == $past(currentFaultThreshold)) else $error("limit stale");
    chk_endless: assert property (@(posedge clock) disable iff (sys_rst)
        (retryCode == `OCF_RETRY_ENDLESS && $past(retryCode) == `OCF_RETRY_ENDLESS
         && $past(state) != ocf_pkg::StLatched) |-> state != ocf_pkg::StLatched)
        else $error("endless retry latched off");
endmodule
`default_nettype wire

// >>> dv/ocf_load_model.sv
// Purpose: Load and output-voltage model on the far side of the power stage
// Assumes: Current exceeds the limit only while the stage is enabled
// Notes:   A dead output draws nothing and shows no voltage
`timescale 1ns/1ps
`default_nettype none
module ocf_load_model (
    // Stage and bench controls
    input  wire logic outputEnable,
    input  wire logic heavyLoad,
    input  wire logic sagLoad,
    // Comparator pins
    output logic      overCurrent,
    output logic      belowCutoff
);
    // ----------------------------------------------------------------
    // Comparators
    // ----------------------------------------------------------------
    // Trip falls with the stage, so every restart sees a fresh edge
    assign overCurrent = outputEnable & heavyLoad;
    assign belowCutoff = sagLoad | ~outputEnable;
endmodule
`default_nettype wire

// >>> dv/overcurrent_fault_response_tb.sv
// Purpose: Self-checking bench for the over-current fault response block
// Assumes: TICK_CYCLES of 1, so a delay unit is unitLen clocks
// Notes:   Random delay codes and units, seed fixed
`timescale 1ns/1ps
`default_nettype none
`include "ocf_cfg.svh"
module overcurrent_fault_response_tb;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        clock = 1'b0;
    logic        sysRst = 1'b1;
    logic [7:0]  regAddr = 8'h00;
    logic        regWrite = 1'b0;
    logic [15:0] regWdata = 16'h0000;
    logic        enableCmd = 1'b0;
    logic        biasGood = 1'b1;
    logic        otherFault = 1'b0;
    logic        faultClear = 1'b0;
    logic        heavyLoad = 1'b0;
    logic        sagLoad = 1'b0;
    logic [15:0] regRdata, currentLimit, q, v;
    logic        overCurrent, belowCutoff, limitActive, outputEnable, faultStatus, hostAlert;
    int          numErrors = 0;
    int          compares = 0;
    int          seed = 80;
    int          rises, minGap, d, u;
    logic [7:0]  ra [4] = '{`OCF_ADDR_THRESHOLD, `OCF_ADDR_ACTION, `OCF_ADDR_TIME_UNIT, 8'h10};
    logic [15:0] rv [4] = '{`OCF_RST_THRESHOLD, {8'h00, `OCF_RST_ACTION}, `OCF_RST_TIME_UNIT, 16'h0000};
    always #25 clock = ~clock;
    ocf_fault_response #(.TICK_CYCLES(1)) ocf_fault_response_inst (
        .clock(clock), .sys_rst(sysRst), .regAddr(regAddr), .regWrite(regWrite),
        .regWdata(regWdata), .regRdata(regRdata), .overCurrent(overCurrent),
        .belowCutoff(belowCutoff), .enableCmd(enableCmd), .biasGood(biasGood),
        .otherFault(otherFault), .faultClear(faultClear), .currentLimit(currentLimit),
        .limitActive(limitActive), .outputEnable(outputEnable), .faultStatus(faultStatus),
        .hostAlert(hostAlert));
    ocf_load_model ocf_load_model_inst (.outputEnable(outputEnable), .heavyLoad(heavyLoad),
        .sagLoad(sagLoad), .overCurrent(overCurrent), .belowCutoff(belowCutoff));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            numErrors++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] dt);
        @(posedge clock);
        #2;
        regAddr = a;
        regWdata = dt;
        regWrite = 1'b1;
        @(posedge clock);
        #2;
        regWrite = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] r);
        @(posedge clock);
        #2;
        regAddr = a;
        @(posedge clock);
        #1;
        r = regRdata;
    endtask
    // Counts restarts and the shortest off gap before one
    task automatic watch(input int cyc);
        int   gap;
        logic prev;
        rises = 0;
        minGap = 9999;
        gap = 0;
        prev = outputEnable;
        repeat (cyc) begin
            @(posedge clock);
            #1;
            if (outputEnable === 1'b1 && prev !== 1'b1) begin
                rises++;
                minGap = (gap < minGap) ? gap : minGap;
            end
            gap = (outputEnable === 1'b1) ? 0 : gap + 1;
            prev = outputEnable;
        end
    endtask
    task automatic wait_for(input bit lim, input logic val, input int most);
        int k;
        k = 0;
        while ((lim ? limitActive : outputEnable) !== val && k < most) begin
            @(posedge clock);
            #1;
            k++;
        end
        check(lim ? limitActive : outputEnable, val, "wait for level");
    endtask
    // Off, clear and back on, then heavy load raised to force an overcurrent
    task automatic fresh(input logic [7:0] act);
        @(posedge clock);
        #2;
        {enableCmd, heavyLoad, sagLoad, otherFault, biasGood, faultClear} = 6'b000011;
        repeat (8) @(posedge clock);
        #2;
        faultClear = 1'b0;
        wr(`OCF_ADDR_ACTION, {8'h00, act});
        @(posedge clock);
        #2;
        enableCmd = 1'b1;
        wait_for(1'b0, 1'b1, 40);
        check(faultStatus, 1'b0, "status after clear");
        @(posedge clock);
        #2;
        heavyLoad = 1'b1;
    endtask
    task automatic end_of_test;
        $display("compares %0d errors %0d", compares, numErrors);
        if (numErrors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        #1000000;
        numErrors++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge clock);
        #2;
        sysRst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(ra[i], q);
            check(q, rv[i], "reset value");
        end
        v = $random(seed);
        wr(`OCF_ADDR_THRESHOLD, v);
        rd(`OCF_ADDR_THRESHOLD, q);
        check(q, v, "threshold readback");
        check(currentLimit, v, "limit to stage");
        $display("test registers done");
        fresh(8'h00);
        repeat (200) @(posedge clock);
        check({limitActive, outputEnable}, 2'b11, "ignore mode runs");
        check({faultStatus, hostAlert}, 2'b11, "status and alert");
        $display("test ignore done");
        fresh(8'h40);
        wait_for(1'b1, 1'b1, 40);
        watch(100);
        check(outputEnable, 1'b1, "conditioned runs");
        #1;
        sagLoad = 1'b1;
        wait_for(1'b0, 1'b0, 30);
        watch(200);
        check(rises, 0, "no retry");
        $display("test conditioned done");
        d = 2 + {$random(seed)} % 4;
        fresh({5'b10000, d[2:0]});
        wait_for(1'b1, 1'b1, 40);
        watch((1 << d) - 4);
        check(outputEnable, 1'b1, "delay still on");
        wait_for(1'b0, 1'b0, (1 << d) + 30);
        fresh(8'h85);
        wait_for(1'b1, 1'b1, 40);
        #1;
        heavyLoad = 1'b0;
        watch(80);
        check(outputEnable, 1'b1, "trip gone, keeps on");
        $display("test delayed done");
        fresh(8'hf8);
        watch(400);
        check(rises >= 8, 1'b1, "endless retry");
        @(posedge clock);
        #2;
        case ({$random(seed)} % 3)
            0: enableCmd = 1'b0;
            1: biasGood = 1'b0;
            default: otherFault = 1'b1;
        endcase
        // A restart already in flight may land while the stop crosses the synchroniser
        repeat (8) @(posedge clock);
        watch(100);
        check(rises, 0, "endless retry stops");
        check(outputEnable, 1'b0, "endless output off");
        $display("test endless done");
        for (int n = 0; n < 7; n++) begin
            d = {$random(seed)} % 3;
            u = 1 + {$random(seed)} % 2;
            wr(`OCF_ADDR_TIME_UNIT, u[15:0]);
            fresh({2'b11, n[2:0], d[2:0]});
            wait_for(1'b0, 1'b0, 8);
            watch(n * ((1 << d) * u + 20) + 100);
            check(rises, n, "restart count");
            if (n > 0) check(minGap >= (1 << d) * u, 1'b1, "restart spacing");
            check({faultStatus, outputEnable}, 2'b10, "off after retries");
        end
        $display("test retries done");
        end_of_test();
    end
endmodule
`default_nettype wire
